/* File: logic/pba_defines.svh */
`ifndef PBA_DEFINES_SVH
`define PBA_DEFINES_SVH

// number of shared contention lines and the index of the "more steps" line
`define PBA_LINES 4
`define PBA_WAIT_LINE 3
// width of the count setting and the last time-step index it can select
`define PBA_CNT_W 4
`define PBA_LAST_STEP 4'hf
// drive setting width, grant queue depth and request pipeline depth
`define PBA_DRV_W 2
`define PBA_GQ_DEPTH 4
`define PBA_PIPE_DEPTH 3
// reset values of the contention drive and the step counter
`define PBA_OE_RESET 4'h0
`define PBA_STEP_RESET 4'h0

`endif

/* File: logic/pba_pkg.sv */
package pba_pkg;

  typedef enum logic [1:0] {
    PBA_IDLE = 2'b00, // not part of the current time-slice
    PBA_HOLD = 2'b01, // joined, waiting for own interval on the wait line
    PBA_BID = 2'b10, // driving the selected low-order line
    PBA_DONE = 2'b11 // placed in the grant queue this time-slice
  } pba_arb_state_type;

  typedef logic [3:0] pba_count_type;
  typedef logic [1:0] pba_drive_type;

endpackage : pba_pkg

/* File: logic/pba_pipe_track.sv */
`timescale 1ns/10ps
`include "pba_defines.svh"

// three-slot pipeline tracker: slot index 0 is the oldest request
module pba_pipe_track #(
  parameter int DEPTH = `PBA_PIPE_DEPTH
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic push, // a request packet enters the pipeline
  input wire logic push_mine, // the entering request is ours
  input wire logic pop, // reply received for the oldest slot
  input wire logic rotate, // deferral seen: oldest moves to the end
  output logic [1:0] count_reg, // occupied slots
  output logic head_mine_reg // oldest slot holds our request
);
  logic [DEPTH-1:0] mine_reg;
  logic [DEPTH-1:0] mine_next;
  logic [DEPTH-1:0] shifted;
  logic [1:0] count_next;
  logic [1:0] base;
  logic do_rot;

  // a completing reply beats a deferral of the same slot
  assign do_rot = rotate && !pop && (count_reg != 2'h0);
  assign base = pop ? count_reg - 2'h1 : count_reg;
  assign count_next = push ? base + 2'h1 : base;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_slot
      always_comb
      begin
        if (pop || do_rot)
        begin
          if (i == DEPTH - 1)
            shifted[i] = 1'b0;
          else
            shifted[i] = mine_reg[(i + 1) % DEPTH];
          if (do_rot && (i == int'(count_reg) - 1))
            shifted[i] = mine_reg[0];
        end
        else
        begin
          shifted[i] = mine_reg[i];
        end
        if (push && (i == int'(base)))
          mine_next[i] = push_mine;
        else
          mine_next[i] = shifted[i];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mine_reg <= '0;
      count_reg <= 2'h0;
      head_mine_reg <= 1'b0;
    end
    else
    begin
      mine_reg <= mine_next;
      count_reg <= count_next;
      head_mine_reg <= mine_next[0] && (count_next != 2'h0);
    end
  end

endmodule : pba_pipe_track

/* File: logic/pba_arbiter.sv */
`timescale 1ns/10ps
`include "pba_defines.svh"

// What this block does
// - new time-slice starts the cycle after all four lines read idle, at step zero
// - bid only in the interval equal to the count setting
// - per interval, line 0 enters the grant queue first, then 1, then 2
// - keep the low-order line asserted until placed in the queue, then release
// - nonzero count asserts line 3 first, switches to low line at own interval
// - an interval ends only when all its bidders are queued
// - an interval with no bidders passes empty; count advances
// - request arriving after the slice's first cycle waits for the next slice
// - with a full queue the winner keeps its line until an entry frees
// - line 3 drops once every joined agent is placed or bidding
// - slice ends when all lines idle; pending requests start a new slice
// - grant queue head moves first-in first-out into the next free slot
// - track three pipeline slots, freed when the matching reply arrives
// - slot 1 oldest; on completion entries shift down, vacancy at slot 3
// - replies answer slot 1 in order unless deferred
// - on deferral, every agent moves slot 1 to the last occupied slot
// - drive deferral only as the server owing the slot 1 reply
// - four-entry queue; while full, arbitration freezes and the step stretches
// - four-bit count picks one of sixteen steps; drive picks lines 0 to 2
// - queue head with under three outstanding takes the bus before replies
// - reply takes the bus when pipeline full, or queue empty and pipeline not empty
module pba_arbiter
  import pba_pkg::*;
(
  input wire logic clock, // 200 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic bus_req, // pulse: local side needs a bus request
  input wire pba_pkg::pba_count_type count_setting, // interval to bid in
  input wire pba_pkg::pba_drive_type drive_setting, // low-order line 0..2
  input wire logic [3:0] contention_lines_in_n, // wire level, low = asserted
  input wire logic reply_deferral_signal_in_n, // wire level, low = asserted
  input wire logic reply_done, // pulse: reply for slot 1 completed
  input wire logic defer_req, // local server wants to defer its reply
  input wire logic reply_owed, // local server owes the slot 1 reply
  output logic [3:0] contention_lines_out_n, // driven level, always low
  output logic [3:0] contention_lines_oe, // high while pulling a line low
  output logic reply_deferral_signal_out_n, // driven level, always low
  output logic reply_deferral_signal_oe, // high while asserting deferral
  output logic request_go, // pulse: our request packet takes the bus
  output logic reply_slot_open, // replies may take the next bus cycle
  output logic reply_due, // slot 1 holds our request
  output logic req_pending, // request waiting for the next slice
  output logic [2:0] gq_fill, // grant queue entries
  output logic [1:0] pipe_fill // outstanding transactions
);
  import pba_pkg::*;

  pba_arb_state_type state_reg;
  pba_arb_state_type state_next;
  logic [3:0] step_reg;
  logic [3:0] step_next;
  logic [3:0] lines_act;
  logic bus_idle;
  logic step_end;
  logic [1:0] win_idx;
  logic place;
  logic my_win;
  logic gq_full;
  logic gq_pop;
  logic [2:0] gq_wr;
  logic [2:0] gq_count_next;
  logic [`PBA_GQ_DEPTH-1:0] gq_mine_reg;
  logic [`PBA_GQ_DEPTH-1:0] gq_mine_next;
  logic [1:0] pipe_count;
  logic pipe_head_mine;
  logic deferral_seen;
  logic join_slice;
  logic [3:0] oe_next;

  assign lines_act = ~contention_lines_in_n;
  assign deferral_seen = !reply_deferral_signal_in_n;
  assign bus_idle = (lines_act == 4'h0);
  // an interval closes once no low-order line is held
  assign step_end = !bus_idle && (lines_act[2:0] == 3'h0);
  assign gq_full = (gq_fill == 3'(`PBA_GQ_DEPTH));

  // lowest asserted low-order line wins the interval
  always_comb
  begin
    if (lines_act[0])
      win_idx = 2'h0;
    else if (lines_act[1])
      win_idx = 2'h1;
    else
      win_idx = 2'h2;
  end

  // a full queue freezes placement, so every line stays as it is
  assign place = (lines_act[2:0] != 3'h0) && !gq_full;
  assign my_win = (state_reg == PBA_BID) && (win_idx == drive_setting);
  assign join_slice = bus_idle && req_pending;

  // state of this agent within the time-slice
  always_comb
  begin
    state_next = state_reg;
    if (bus_idle)
    begin
      if (!req_pending)
        state_next = PBA_IDLE;
      else if (count_setting == 4'h0)
        state_next = PBA_BID;
      else
        state_next = PBA_HOLD;
    end
    else
    begin
      unique case (state_reg)
        PBA_IDLE: state_next = PBA_IDLE;
        PBA_HOLD:
          if (step_end && (count_setting == step_reg + 4'h1))
            state_next = PBA_BID;
        PBA_BID:
          if (my_win && place)
            state_next = PBA_DONE;
        PBA_DONE: state_next = PBA_DONE;
      endcase
    end
  end

  always_comb
  begin
    if (bus_idle)
      step_next = `PBA_STEP_RESET;
    else if (step_end && (step_reg != `PBA_LAST_STEP))
      step_next = step_reg + 4'h1;
    else
      step_next = step_reg;
  end

  // line drive follows the next state so the wire moves with the state
  always_comb
  begin
    oe_next = 4'h0;
    if (state_next == PBA_HOLD)
      oe_next[`PBA_WAIT_LINE] = 1'b1;
    if (state_next == PBA_BID)
      oe_next[drive_setting] = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= PBA_IDLE;
      step_reg <= `PBA_STEP_RESET;
      contention_lines_oe <= `PBA_OE_RESET;
      contention_lines_out_n <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      step_reg <= step_next;
      contention_lines_oe <= oe_next;
      contention_lines_out_n <= 4'h0;
    end
  end

  // requests raised after the slice's first cycle wait; a new one wins a clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      req_pending <= 1'b0;
    else
      req_pending <= bus_req || (req_pending && !join_slice);
  end

  // grant queue: every agent mirrors the order, marking its own entries
  assign gq_pop = (gq_fill != 3'h0) && (pipe_count < 2'(`PBA_PIPE_DEPTH));
  assign gq_wr = gq_pop ? gq_fill - 3'h1 : gq_fill;
  assign gq_count_next = place ? gq_wr + 3'h1 : gq_wr;

  genvar i;
  generate
    for (i = 0; i < `PBA_GQ_DEPTH; i++)
    begin : g_gq
      always_comb
      begin
        if (place && (i == int'(gq_wr)))
          gq_mine_next[i] = my_win;
        else if (gq_pop)
          gq_mine_next[i] = (i == `PBA_GQ_DEPTH - 1) ? 1'b0 :
            gq_mine_reg[(i + 1) % `PBA_GQ_DEPTH];
        else
          gq_mine_next[i] = gq_mine_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gq_mine_reg <= '0;
      gq_fill <= 3'h0;
    end
    else
    begin
      gq_mine_reg <= gq_mine_next;
      gq_fill <= gq_count_next;
    end
  end

  pba_pipe_track #(
    .DEPTH(`PBA_PIPE_DEPTH)
  ) u_pipe (
    .clock(clock),
    .rst_n(rst_n),
    .push(gq_pop),
    .push_mine(gq_mine_reg[0]),
    .pop(reply_done),
    .rotate(deferral_seen),
    .count_reg(pipe_count),
    .head_mine_reg(pipe_head_mine)
  );

  // bus sequencing and deferral outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      request_go <= 1'b0;
      reply_slot_open <= 1'b0;
      reply_due <= 1'b0;
      pipe_fill <= 2'h0;
      reply_deferral_signal_oe <= 1'b0;
      reply_deferral_signal_out_n <= 1'b0;
    end
    else
    begin
      request_go <= gq_pop && gq_mine_reg[0];
      reply_slot_open <= (pipe_count == 2'(`PBA_PIPE_DEPTH)) ||
        ((gq_fill == 3'h0) && (pipe_count != 2'h0));
      reply_due <= pipe_head_mine;
      pipe_fill <= pipe_count;
      reply_deferral_signal_oe <= defer_req && reply_owed &&
        (pipe_count != 2'h0) && !reply_done;
      reply_deferral_signal_out_n <= 1'b0;
    end
  end

  // checks that the block keeps its own side of the protocol
  sequence s_idle_seen;
    contention_lines_in_n == 4'hf;
  endsequence

  sequence s_slice_open;
    step_reg == 4'h0;
  endsequence

  a_slice_step_zero: assert property (@(posedge clock) disable iff (!rst_n)
    s_idle_seen |=> s_slice_open)
    else $error("time-slice did not open at step zero");

  a_bid_own_step: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == PBA_BID) |-> (count_setting == step_reg))
    else $error("bidding outside own interval");

  a_hold_wait_line: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == PBA_HOLD) |-> contention_lines_oe == 4'h8)
    else $error("waiting agent not on line 3 alone");

  a_release_placed: assert property (@(posedge clock) disable iff (!rst_n)
    (my_win && place) |=> (contention_lines_oe == 4'h0))
    else $error("line kept after queue placement");

  a_full_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    (gq_full && !gq_pop && lines_act[2:0] != 3'h0) |=>
      $stable(contention_lines_oe) && $stable(step_reg))
    else $error("arbitration moved while queue full");

  a_empty_step: assert property (@(posedge clock) disable iff (!rst_n)
    (step_end && step_reg != 4'hf) |=> step_reg == $past(step_reg) + 4'h1)
    else $error("empty interval did not advance");

  a_late_request: assert property (@(posedge clock) disable iff (!rst_n)
    (bus_req && !bus_idle && state_reg == PBA_IDLE) |=>
      req_pending && state_reg == PBA_IDLE)
    else $error("late request joined running slice");

  a_defer_owner: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(reply_deferral_signal_oe) |-> $past(reply_owed) && $past(defer_req))
    else $error("deferral driven by non-owner");

  a_queue_bound: assert property (@(posedge clock) disable iff (!rst_n)
    gq_fill <= 3'h4 && pipe_count <= 2'h3)
    else $error("queue or pipeline overfilled");

  a_head_to_slot: assert property (@(posedge clock) disable iff (!rst_n)
    (gq_pop && !reply_done) |=> pipe_count == $past(pipe_count) + 2'h1)
    else $error("queue head did not take a slot");

endmodule : pba_arbiter

/* File: dv/pba_peer_model.sv */
`timescale 1ns/10ps

// a peer agent: waits on line 3 until its step, then bids on one low-order line
module pba_peer_model (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic arm, // pulse: peer wants the bus
  input wire logic [1:0] drv, // low-order line to drive
  input wire logic [3:0] cnt, // step to bid in
  input wire logic room, // shared grant queue has a free entry
  input wire logic defer, // level: peer server defers
  input wire logic [3:0] lines_n, // resolved contention lines
  output logic [3:0] oe, // high while pulling a line low
  output logic defer_oe // high while asserting deferral
);
  logic pend_reg;
  logic [3:0] left_reg;
  logic [2:0] low_act;
  logic idle;
  logic step_end;
  logic placed;

  assign low_act = ~lines_n[2:0];
  assign idle = (lines_n == 4'hf);
  assign step_end = !idle && (low_act == 3'h0);
  // queued when no lower low-order line is asserted and the queue has room
  assign placed = (oe[2:0] != 3'h0) && room && ((low_act & (oe[2:0] - 3'h1)) == 3'h0);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_reg <= 1'b0;
      left_reg <= 4'h0;
      oe <= 4'h0;
    end
    else if (pend_reg && idle) // joins only after an idle cycle
    begin
      pend_reg <= arm;
      left_reg <= cnt;
      oe <= (cnt == 4'h0) ? (4'h1 << drv) : 4'h8;
    end
    else
    begin
      if (arm)
        pend_reg <= 1'b1;
      // line stays low until this peer is queued
      if (placed)
        oe <= 4'h0;
      if (oe[3] && step_end)
      begin
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h1)
          oe <= 4'h1 << drv;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      defer_oe <= 1'b0;
    else
      defer_oe <= defer; // follows defer one cycle later, with no check of owing the slot 1 reply
  end
endmodule : pba_peer_model

/* File: dv/pba_arbiter_tb_top.sv */
`timescale 1ns/10ps

module pba_arbiter_tb_top;
  import pba_pkg::*;
  logic clock, rst_n, bus_req, reply_done, defer_req, reply_owed;
  logic arm, pdef, request_go, reply_slot_open, reply_due, req_pending, doe, pdoe, dn, dout_n;
  pba_count_type count_setting;
  pba_drive_type drive_setting;
  logic [1:0] pdrv, pipe_fill;
  logic [3:0] pcnt, oe, poe, lines_n, out_n;
  logic [2:0] gq_fill;
  int n_errors, num_checks;

  // open-drain wire: low while any agent pulls it
  assign lines_n = ~(oe | poe);
  assign dn = ~(doe | pdoe);

  pba_arbiter i_dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
    .count_setting(count_setting), .drive_setting(drive_setting),
    .contention_lines_in_n(lines_n), .reply_deferral_signal_in_n(dn),
    .reply_done(reply_done), .defer_req(defer_req), .reply_owed(reply_owed),
    .contention_lines_out_n(out_n), .contention_lines_oe(oe),
    .reply_deferral_signal_out_n(dout_n), .reply_deferral_signal_oe(doe),
    .request_go(request_go), .reply_slot_open(reply_slot_open),
    .reply_due(reply_due), .req_pending(req_pending), .gq_fill(gq_fill),
    .pipe_fill(pipe_fill));

  pba_peer_model i_peer (.clock(clock), .rst_n(rst_n), .arm(arm), .drv(pdrv),
    .cnt(pcnt), .room(gq_fill != 3'h4), .defer(pdef), .lines_n(lines_n), .oe(poe),
    .defer_oe(pdoe));

  always #2.5 clock = ~clock;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic wait_oe(input logic [3:0] v, input int lim);
    int k;
    k = 0;
    while (oe !== v && k < lim)
    begin
      cyc(1);
      k++;
    end
  endtask : wait_oe

  // one request pulse, optionally with the peer armed in the same cycle
  task automatic req(input logic [3:0] c, input logic [1:0] d, input logic pa);
    @(posedge clock);
    count_setting <= c;
    drive_setting <= d;
    bus_req <= 1'b1;
    arm <= pa;
    @(posedge clock);
    bus_req <= 1'b0;
    arm <= 1'b0;
    #1;
  endtask : req

  task automatic pop();
    @(posedge clock);
    reply_done <= 1'b1;
    @(posedge clock);
    reply_done <= 1'b0;
    cyc(2);
  endtask : pop

  task automatic one();
    req(4'h0, 2'h0, 1'b0);
    wait_oe(4'h1, 4);
    wait_oe(4'h0, 6);
  endtask : one

  task automatic t_basic();
    chk("oe at reset", 8'h0, {4'h0, oe});
    chk("fills at reset", 8'h0, {2'h0, gq_fill, pipe_fill, doe});
    chk("drive levels", 8'h0, {3'h0, out_n, dout_n});
    req(4'h0, 2'h0, 1'b0);
    wait_oe(4'h1, 4);
    chk("bid line", 8'h1, {4'h0, oe});
    wait_oe(4'h0, 4);
    cyc(1);
    chk("request_go", 8'h1, {7'h0, request_go});
    cyc(1);
    chk("pipe one", 8'h1, {6'h0, pipe_fill});
    chk("reply_due", 8'h1, {7'h0, reply_due});
    chk("reply open", 8'h1, {7'h0, reply_slot_open});
    pop();
    chk("pipe empty", 8'h0, {6'h0, pipe_fill});
    $display("basic done");
  endtask : t_basic

  task automatic t_prio();
    pdrv <= 2'h0;
    pcnt <= 4'h0;
    req(4'h0, 2'h1, 1'b1);
    wait_oe(4'h2, 4);
    chk("line 1 bid", 8'h2, {4'h0, oe});
    cyc(1);
    chk("line 1 held", 8'h2, {4'h0, oe});
    wait_oe(4'h0, 4);
    chk("line 1 freed", 8'h0, {4'h0, oe});
    cyc(2);
    chk("second slot", 8'h2, {6'h0, pipe_fill});
    chk("peer first", 8'h0, {7'h0, reply_due});
    pop();
    chk("moved to slot 1", 8'h1, {7'h0, reply_due});
    pop();
    $display("prio done");
  endtask : t_prio

  task automatic t_count(input logic [3:0] c, input logic [1:0] d);
    req(c, d, 1'b0);
    wait_oe(4'h8, 4);
    chk("wait line", 8'h8, {4'h0, oe});
    wait_oe(4'h1 << d, 24);
    chk("own step", {4'h0, 4'h1 << d}, {4'h0, oe});
    wait_oe(4'h0, 4);
    cyc(3);
    pop();
    chk("count pipe", 8'h0, {6'h0, pipe_fill});
    $display("count done");
  endtask : t_count

  task automatic t_late();
    pdrv <= 2'h0;
    pcnt <= 4'h3;
    @(posedge clock);
    arm <= 1'b1;
    @(posedge clock);
    arm <= 1'b0;
    cyc(1);
    // peer holds line 3 through steps 0 to 2, so our request lands mid-slice
    req(4'h0, 2'h0, 1'b0);
    chk("late held off", 8'h0, {4'h0, oe});
    chk("late pending", 8'h1, {7'h0, req_pending});
    wait_oe(4'h1, 12);
    chk("late joins", 8'h1, {4'h0, oe});
    wait_oe(4'h0, 4);
    cyc(3);
    pop();
    pop();
    $display("late done");
  endtask : t_late

  task automatic t_full();
    repeat (7) one();
    cyc(2);
    chk("pipe full", 8'h3, {6'h0, pipe_fill});
    chk("queue full", 8'h4, {5'h0, gq_fill});
    chk("reply open full", 8'h1, {7'h0, reply_slot_open});
    req(4'h0, 2'h0, 1'b0);
    wait_oe(4'h1, 4);
    cyc(4);
    chk("stalled bid", 8'h1, {4'h0, oe});
    pop();
    wait_oe(4'h0, 6);
    chk("placed", 8'h0, {4'h0, oe});
    cyc(2);
    chk("queue refilled", 8'h4, {5'h0, gq_fill});
    repeat (7) pop();
    chk("drained", 8'h0, {3'h0, gq_fill, pipe_fill});
    $display("full done");
  endtask : t_full

  task automatic t_defer();
    pdrv <= 2'h0;
    pcnt <= 4'h0;
    req(4'h0, 2'h1, 1'b1);
    wait_oe(4'h2, 4);
    wait_oe(4'h0, 4);
    cyc(2);
    @(posedge clock);
    defer_req <= 1'b1;
    cyc(2);
    chk("defer unowed", 8'h0, {7'h0, doe});
    @(posedge clock);
    reply_owed <= 1'b1;
    // one sampled cycle of ownership gives exactly one rotation
    @(posedge clock);
    defer_req <= 1'b0;
    reply_owed <= 1'b0;
    #1;
    chk("defer owed", 8'h1, {7'h0, doe});
    cyc(2);
    chk("defer keeps", 8'h2, {6'h0, pipe_fill});
    chk("defer head", 8'h1, {7'h0, reply_due});
    @(posedge clock);
    pdef <= 1'b1;
    @(posedge clock);
    pdef <= 1'b0;
    cyc(2);
    chk("peer defer", 8'h0, {7'h0, reply_due});
    pop();
    pop();
    chk("defer drained", 8'h0, {6'h0, pipe_fill});
    $display("defer done");
  endtask : t_defer

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  initial
  begin
    {clock, rst_n, bus_req, reply_done, defer_req, reply_owed, arm, pdef} = 8'h0;
    count_setting = 4'h0;
    drive_setting = 2'h0;
    pdrv = 2'h0;
    pcnt = 4'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    cyc(1);
    t_basic();
    t_prio();
    t_count(4'h2, 2'h0);
    t_count(4'hf, 2'h2);
    t_late();
    t_full();
    t_defer();
    final_report();
  end

  // the tests need well under a thousand cycles
  initial
  begin
    #20000;
    n_errors++;
    final_report();
  end
endmodule : pba_arbiter_tb_top
